// *** src/suart_core.sv ***
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ps
module suart_core #(
  parameter int F8_DIV = 8
) (
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic                  serial_in_pin,
  output logic                       serial_out_pin_o,
  output logic                       serial_out_pin_oe,
  input  wire logic                  ext_clock_pin,
  input  wire logic                  cts_n_pin,
  output logic                       rts_n_pin,
  output logic                       tx_irq_req,
  output logic                       rx_irq_req
);
  import suart_pkg::*;

  if (F8_DIV < 2 || F8_DIV > 256) begin : g_chk
    $error("F8_DIV out of range");
  end

  function automatic logic [3:0] char_len(input logic [2:0] m);
    unique case (m)
      MODE_7:  char_len = 4'd7;
      MODE_9:  char_len = 4'd9;
      default: char_len = 4'd8;
    endcase
  endfunction

  function automatic logic [8:0] char_mask(input logic [2:0] m);
    unique case (m)
      MODE_7:  char_mask = 9'h07F;
      MODE_9:  char_mask = 9'h1FF;
      default: char_mask = 9'h0FF;
    endcase
  endfunction

  // Self-inverse, so the receiver undoes with the same call
  function automatic logic [8:0] prep_char(input logic [8:0] d, input logic [2:0] m,
                                           input logic inv, input logic msb);
    logic [8:0] x;
    x = d & char_mask(m);
    if (inv) begin
      x = x ^ char_mask(m);
    end
    if (msb && m == MODE_8) begin
      for (int i = 0; i < 8; i++) begin
        x[i] = d[7 - i] ^ inv;
      end
    end
    prep_char = x;
  endfunction

  // Register state
  logic [8:0]    txb_r, txb_nxt;
  logic [8:0]    rxb_r, rxb_nxt;
  logic [7:0]    brg_div_r, brg_div_nxt;
  logic [7:0]    mode_r, mode_nxt;
  logic [7:0]    c0_r, c0_nxt;
  logic [7:0]    c1_r, c1_nxt;
  logic [7:0]    sm_r [4];
  logic [7:0]    sm_nxt [4];
  logic [3:0]    pre_field_r, pre_field_nxt;
  logic          tbe_r, tbe_nxt;
  logic          ri_r, ri_nxt;
  suart_err_type err_r, err_nxt;
  logic          ack_nxt;
  logic [31:0]   dat_nxt;
  logic          wr_now, rd_rxb;

  // Synchronisers
  logic rx_s1, rx_s2, ext_s1, ext_s2, ext_s3, cts_s1, cts_s2;

  // Config views
  logic [2:0] smode;
  logic       uart_on, par_en, par_even, two_stop, pol, od, msb, inv, hs_on, hs_rts;
  assign smode    = mode_r[2:0];
  assign uart_on  = smode == MODE_7 || smode == MODE_8 || smode == MODE_9;
  assign par_en   = mode_r[MD_PAREN];
  assign par_even = mode_r[MD_EVEN];
  assign two_stop = mode_r[MD_STOP];
  assign pol      = mode_r[MD_PIN_POLARITY_INVERT];
  assign od       = c0_r[C0_OD];
  assign msb      = c0_r[C0_MSB];
  assign inv      = c1_r[C1_LCH];
  assign hs_on    = !c0_r[C0_HSDIS];
  assign hs_rts   = c0_r[C0_HSSEL];

  // Baud generation
  logic [7:0] div8_r, div8_nxt;
  logic [4:0] pre_r, pre_nxt;
  logic [7:0] brg_r, brg_nxt;
  logic       ovs_tick_r, ovs_tick_nxt;
  logic       f2n_tick, src_tick;

  always_comb begin
    f2n_tick = pre_field_r == 4'd0 || pre_r == {pre_field_r, 1'b0} - 5'd1;
    pre_nxt  = f2n_tick ? 5'd0 : pre_r + 5'd1;
    div8_nxt = (div8_r == 8'(F8_DIV - 1)) ? 8'd0 : div8_r + 8'd1;
    if (mode_r[MD_CLOCK_SOURCE_DIR]) begin
      src_tick = ext_s2 && !ext_s3;
    end else begin
      unique case (c0_r[1:0])
        2'd1:    src_tick = div8_r == 8'(F8_DIV - 1);
        2'd2:    src_tick = f2n_tick;
        default: src_tick = 1'b1;
      endcase
    end
    brg_nxt      = brg_r;
    ovs_tick_nxt = 1'b0;
    if (src_tick) begin
      if (brg_r == 8'd0) begin
        brg_nxt      = brg_div_r;
        ovs_tick_nxt = 1'b1;
      end else begin
        brg_nxt = brg_r - 8'd1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      div8_r     <= 8'h00;
      pre_r      <= 5'h00;
      brg_r      <= 8'h00;
      ovs_tick_r <= 1'b0;
      {rx_s1, rx_s2, ext_s1, ext_s2, ext_s3, cts_s1, cts_s2} <= 7'h7F;
    end else begin
      div8_r     <= div8_nxt;
      pre_r      <= pre_nxt;
      brg_r      <= brg_nxt;
      ovs_tick_r <= ovs_tick_nxt;
      rx_s1      <= serial_in_pin;
      rx_s2      <= rx_s1;
      ext_s1     <= ext_clock_pin;
      ext_s2     <= ext_s1;
      ext_s3     <= ext_s2;
      cts_s1     <= cts_n_pin;
      cts_s2     <= cts_s1;
    end
  end

  // Transmitter
  suart_tx_state_type tx_st_r, tx_st_nxt;
  logic [8:0] tx_sh_r, tx_sh_nxt;
  logic [3:0] tx_ph_r, tx_ph_nxt, tx_bits_r, tx_bits_nxt;
  logic       tx_par_r, tx_par_nxt, tx_stp_r, tx_stp_nxt, tx_line_r, tx_line_nxt;
  logic       tx_load, tx_done, cts_ok, tx_lvl;
  logic       pin_o_nxt, pin_oe_nxt, tirq_nxt;

  assign cts_ok  = !hs_on || hs_rts || !cts_s2;
  assign tx_load = tx_st_r == TX_IDLE && uart_on && c1_r[C1_TE] && !tbe_r && cts_ok;

  always_comb begin
    tx_st_nxt   = tx_st_r;
    tx_sh_nxt   = tx_sh_r;
    tx_ph_nxt   = tx_ph_r;
    tx_bits_nxt = tx_bits_r;
    tx_par_nxt  = tx_par_r;
    tx_stp_nxt  = tx_stp_r;
    tx_line_nxt = tx_line_r;
    tx_done     = 1'b0;
    if (tx_load) begin
      tx_sh_nxt   = prep_char(txb_r, smode, inv, msb);
      tx_par_nxt  = (^prep_char(txb_r, smode, inv, msb)) ^ !par_even;
      tx_st_nxt   = TX_START;
      tx_ph_nxt   = 4'd0;
      tx_line_nxt = 1'b0;
    end else if (tx_st_r != TX_IDLE && ovs_tick_r) begin
      tx_ph_nxt = tx_ph_r + 4'd1;
      if (tx_ph_r == OVS_LAST) begin
        unique case (tx_st_r)
          TX_START: begin
            tx_st_nxt   = TX_DATA;
            tx_bits_nxt = char_len(smode) - 4'd1;
            tx_line_nxt = tx_sh_r[0];
          end
          TX_DATA: begin
            tx_sh_nxt   = {1'b0, tx_sh_r[8:1]};
            tx_bits_nxt = tx_bits_r - 4'd1;
            tx_line_nxt = tx_sh_r[1];
            if (tx_bits_r == 4'd0) begin
              tx_st_nxt   = par_en ? TX_PAR : TX_STOP;
              tx_line_nxt = par_en ? tx_par_r : 1'b1;
              tx_stp_nxt  = two_stop;
            end
          end
          TX_PAR: begin
            tx_st_nxt   = TX_STOP;
            tx_line_nxt = 1'b1;
            tx_stp_nxt  = two_stop;
          end
          TX_STOP: begin
            tx_stp_nxt = 1'b0;
            if (!tx_stp_r) begin
              tx_st_nxt = TX_IDLE;
              tx_done   = 1'b1;
            end
          end
          default: tx_st_nxt = TX_IDLE;
        endcase
      end
    end
    if (tx_st_nxt == TX_IDLE) begin
      tx_line_nxt = 1'b1;
    end
    tx_lvl     = tx_line_nxt ^ pol;
    pin_o_nxt  = od ? 1'b0 : tx_lvl;
    pin_oe_nxt = od ? !tx_lvl : 1'b1;
    tirq_nxt   = c1_r[C1_IRS] ? tx_done : tx_load;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tx_st_r           <= TX_IDLE;
      tx_sh_r           <= 9'h000;
      tx_ph_r           <= 4'h0;
      tx_bits_r         <= 4'h0;
      tx_par_r          <= 1'b0;
      tx_stp_r          <= 1'b0;
      tx_line_r         <= 1'b1;
      serial_out_pin_o  <= 1'b1;
      serial_out_pin_oe <= 1'b1;
      tx_irq_req        <= 1'b0;
    end else begin
      tx_st_r           <= tx_st_nxt;
      tx_sh_r           <= tx_sh_nxt;
      tx_ph_r           <= tx_ph_nxt;
      tx_bits_r         <= tx_bits_nxt;
      tx_par_r          <= tx_par_nxt;
      tx_stp_r          <= tx_stp_nxt;
      tx_line_r         <= tx_line_nxt;
      serial_out_pin_o  <= pin_o_nxt;
      serial_out_pin_oe <= pin_oe_nxt;
      tx_irq_req        <= tirq_nxt;
    end
  end

  // Receiver
  suart_rx_state_type rx_st_r, rx_st_nxt;
  logic [8:0] rx_sh_r, rx_sh_nxt;
  logic [3:0] rx_ph_r, rx_ph_nxt, rx_idx_r, rx_idx_nxt;
  logic       rx_pb_r, rx_pb_nxt, rx_frm_r, rx_frm_nxt;
  logic       rx_lvl, rx_smp, ov_pt, rx_done, rirq_nxt, rts_nxt;

  assign rx_lvl = rx_s2 ^ pol;
  assign rx_smp = ovs_tick_r && rx_ph_r == OVS_LAST;

  always_comb begin
    rx_st_nxt  = rx_st_r;
    rx_sh_nxt  = rx_sh_r;
    rx_ph_nxt  = ovs_tick_r ? rx_ph_r + 4'd1 : rx_ph_r;
    rx_idx_nxt = rx_idx_r;
    rx_pb_nxt  = rx_pb_r;
    rx_frm_nxt = rx_frm_r;
    ov_pt      = 1'b0;
    rx_done    = 1'b0;
    unique case (rx_st_r)
      RX_IDLE: begin
        rx_ph_nxt = 4'd0;
        if (c1_r[C1_RE] && uart_on && !rx_lvl) begin
          rx_st_nxt = RX_START;
        end
      end
      RX_START: begin
        // Recheck at mid start bit to reject glitches
        if (ovs_tick_r && rx_ph_r == OVS_MID) begin
          rx_ph_nxt  = 4'd0;
          rx_idx_nxt = 4'd0;
          rx_sh_nxt  = 9'h000;
          rx_frm_nxt = 1'b0;
          rx_st_nxt  = rx_lvl ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (rx_smp) begin
          rx_sh_nxt[rx_idx_r] = rx_lvl;
          rx_idx_nxt = rx_idx_r + 4'd1;
          if (rx_idx_r == char_len(smode) - 4'd1) begin
            rx_st_nxt = par_en ? RX_PAR : RX_STOP1;
            ov_pt     = !par_en && !two_stop;
          end
        end
      end
      RX_PAR: begin
        if (rx_smp) begin
          rx_pb_nxt = rx_lvl;
          rx_st_nxt = RX_STOP1;
          ov_pt     = !two_stop;
        end
      end
      RX_STOP1: begin
        if (rx_smp) begin
          rx_frm_nxt = !rx_lvl;
          if (two_stop) begin
            rx_st_nxt = RX_STOP2;
            ov_pt     = 1'b1;
          end else begin
            rx_st_nxt = RX_IDLE;
            rx_done   = 1'b1;
          end
        end
      end
      RX_STOP2: begin
        if (rx_smp) begin
          rx_frm_nxt = rx_frm_r || !rx_lvl;
          rx_st_nxt  = RX_IDLE;
          rx_done    = 1'b1;
        end
      end
      default: rx_st_nxt = RX_IDLE;
    endcase
    if (!c1_r[C1_RE]) begin
      rx_st_nxt = RX_IDLE;
    end
    // Overrun already holds the request flag high, so no new pulse
    rirq_nxt = rx_done && !err_nxt.overrun;
    rts_nxt  = !(hs_on && hs_rts) || !(c1_r[C1_RE] && !ri_r);
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rx_st_r    <= RX_IDLE;
      rx_sh_r    <= 9'h000;
      rx_ph_r    <= 4'h0;
      rx_idx_r   <= 4'h0;
      rx_pb_r    <= 1'b0;
      rx_frm_r   <= 1'b0;
      rx_irq_req <= 1'b0;
      rts_n_pin  <= 1'b1;
    end else begin
      rx_st_r    <= rx_st_nxt;
      rx_sh_r    <= rx_sh_nxt;
      rx_ph_r    <= rx_ph_nxt;
      rx_idx_r   <= rx_idx_nxt;
      rx_pb_r    <= rx_pb_nxt;
      rx_frm_r   <= rx_frm_nxt;
      rx_irq_req <= rirq_nxt;
      rts_n_pin  <= rts_nxt;
    end
  end

  // Register file and Wishbone slave
  assign wr_now = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
  assign rd_rxb = wb_cyc_i && wb_stb_i && wb_ack_o && !wb_we_i && wb_adr_i == ADR_RXB;

  always_comb begin
    txb_nxt       = txb_r;
    brg_div_nxt   = brg_div_r;
    mode_nxt      = mode_r;
    c0_nxt        = c0_r;
    c1_nxt        = c1_r;
    sm_nxt        = sm_r;
    pre_field_nxt = pre_field_r;
    rxb_nxt       = rxb_r;
    err_nxt       = err_r;
    tbe_nxt       = tx_load ? 1'b1 : tbe_r;
    ri_nxt        = rd_rxb ? 1'b0 : ri_r;
    if (wr_now && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        ADR_TXB:  txb_nxt[7:0]  = wb_dat_i[7:0];
        ADR_BRG:  brg_div_nxt   = wb_dat_i[7:0];
        ADR_MODE: mode_nxt      = wb_dat_i[7:0];
        ADR_C0:   c0_nxt        = wb_dat_i[7:0];
        ADR_C1:   c1_nxt        = wb_dat_i[7:0];
        ADR_SMA:  sm_nxt[0]     = wb_dat_i[7:0];
        ADR_SMB:  sm_nxt[1]     = wb_dat_i[7:0];
        ADR_SMC:  sm_nxt[2]     = wb_dat_i[7:0];
        ADR_SMD:  sm_nxt[3]     = wb_dat_i[7:0];
        ADR_PRE:  pre_field_nxt = wb_dat_i[3:0];
        default:  txb_nxt       = txb_r;
      endcase
    end
    if (wr_now && wb_sel_i[1] && wb_adr_i == ADR_TXB) begin
      txb_nxt[8] = wb_dat_i[8];
    end
    if (wr_now && wb_adr_i == ADR_TXB && (wb_sel_i[0] || wb_sel_i[1])) begin
      tbe_nxt = 1'b0;
    end
    if (!c1_r[C1_RE]) begin
      err_nxt = '0;
    end
    if (ov_pt && ri_r) begin
      err_nxt.overrun = 1'b1;
    end
    if (rx_done) begin
      rxb_nxt        = prep_char(rx_sh_r, smode, inv, msb);
      err_nxt.framing = rx_frm_nxt;
      err_nxt.parity  = par_en && ((^(rx_sh_r & char_mask(smode))) ^ rx_pb_r ^ !par_even);
      ri_nxt         = 1'b1;
    end
    ack_nxt = wb_cyc_i && wb_stb_i && !wb_ack_o;
    dat_nxt = 32'h0000_0000;
    unique case (wb_adr_i)
      ADR_RXB: begin
        dat_nxt[8:0]    = rxb_r;
        dat_nxt[RB_OVR] = err_r.overrun;
        dat_nxt[RB_FRM] = err_r.framing;
        dat_nxt[RB_PAR] = err_r.parity;
        dat_nxt[RB_SUM] = |err_r;
      end
      ADR_BRG:  dat_nxt[7:0] = brg_div_r;
      ADR_MODE: dat_nxt[7:0] = mode_r;
      ADR_C0: begin
        dat_nxt[7:0]     = c0_r;
        dat_nxt[C0_SHEMP] = tx_st_r == TX_IDLE;
      end
      ADR_C1: begin
        dat_nxt[7:0]   = c1_r;
        dat_nxt[C1_TBE] = tbe_r;
        dat_nxt[C1_RI]  = ri_r;
      end
      ADR_SMA:  dat_nxt[7:0] = sm_r[0];
      ADR_SMB:  dat_nxt[7:0] = sm_r[1];
      ADR_SMC:  dat_nxt[7:0] = sm_r[2];
      ADR_SMD:  dat_nxt[7:0] = sm_r[3];
      ADR_PRE:  dat_nxt[3:0] = pre_field_r;
      default:  dat_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      txb_r       <= 9'h000;
      rxb_r       <= 9'h000;
      brg_div_r   <= 8'h00;
      mode_r      <= 8'h00;
      c0_r        <= C0_RESET;
      c1_r        <= 8'h00;
      sm_r        <= '{default: 8'h00};
      pre_field_r <= 4'h0;
      tbe_r       <= 1'b1;
      ri_r        <= 1'b0;
      err_r       <= '0;
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h0000_0000;
    end else begin
      txb_r       <= txb_nxt;
      rxb_r       <= rxb_nxt;
      brg_div_r   <= brg_div_nxt;
      mode_r      <= mode_nxt;
      c0_r        <= c0_nxt;
      c1_r        <= c1_nxt;
      sm_r        <= sm_nxt;
      pre_field_r <= pre_field_nxt;
      tbe_r       <= tbe_nxt;
      ri_r        <= ri_nxt;
      err_r       <= err_nxt;
      wb_ack_o    <= ack_nxt;
      wb_dat_o    <= dat_nxt;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_load_start;
    tx_load ##1 (!tx_line_r && tx_st_r == TX_START);
  endsequence

  AST_TX_START_COND: assert property (tx_load |-> c1_r[C1_TE] && !tbe_r && cts_ok)
    else $error("transmit started without its conditions");
  AST_TX_START_BIT: assert property (tx_load |-> s_load_start)
    else $error("start bit not driven low after load");
  AST_TXIRQ_CAUSE0: assert property (tx_load && !c1_r[C1_IRS] |=> tx_irq_req && tbe_r)
    else $error("missing transmit irq on buffer transfer");
  AST_TXIRQ_CAUSE1: assert property (tx_done && c1_r[C1_IRS] |=> tx_irq_req && tx_st_r == TX_IDLE)
    else $error("missing transmit irq at shift end");
  AST_RX_IRQ: assert property (rx_irq_req |-> ri_r && !err_r.overrun)
    else $error("receive irq without completed character");
  AST_OVERRUN: assert property (ov_pt && ri_r && c1_r[C1_RE] |=> err_r.overrun)
    else $error("overrun not flagged");
  AST_ERR_SUM: assert property (wb_ack_o && wb_adr_i == ADR_RXB && !wb_we_i
                                |-> wb_dat_o[RB_SUM] == (|wb_dat_o[RB_PAR:RB_OVR]))
    else $error("error sum disagrees with flags");
  // Next state, not current: a load from idle drives the start bit at once
  AST_IDLE_PIN: assert property ($past(tx_st_nxt == TX_IDLE) && !$past(pol) && !$past(od)
                                 |-> serial_out_pin_o && serial_out_pin_oe)
    else $error("idle transmit pin not high");
  AST_WB_ACK: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
endmodule

// *** shared/suart_pkg.sv ***
package suart_pkg;
  localparam logic [7:0] ADR_TXB  = 8'h00;
  localparam logic [7:0] ADR_RXB  = 8'h04;
  localparam logic [7:0] ADR_BRG  = 8'h08;
  localparam logic [7:0] ADR_MODE = 8'h0C;
  localparam logic [7:0] ADR_C0   = 8'h10;
  localparam logic [7:0] ADR_C1   = 8'h14;
  localparam logic [7:0] ADR_SMA  = 8'h18;
  localparam logic [7:0] ADR_SMB  = 8'h1C;
  localparam logic [7:0] ADR_SMC  = 8'h20;
  localparam logic [7:0] ADR_SMD  = 8'h24;
  localparam logic [7:0] ADR_PRE  = 8'h28;
  // serial_mode_ctrl fields
  localparam int MD_CLOCK_SOURCE_DIR = 3;
  localparam int MD_STOP  = 4;
  localparam int MD_EVEN  = 5;
  localparam int MD_PAREN = 6;
  localparam int MD_PIN_POLARITY_INVERT = 7;
  // serial_ctrl_zero fields
  localparam int C0_HSSEL = 2;
  localparam int C0_SHEMP = 3;
  localparam int C0_HSDIS = 4;
  localparam int C0_OD    = 5;
  localparam int C0_MSB   = 7;
  // serial_ctrl_one fields
  localparam int C1_TE    = 0;
  localparam int C1_TBE   = 1;
  localparam int C1_RE    = 2;
  localparam int C1_RI    = 3;
  localparam int C1_IRS   = 4;
  localparam int C1_LCH   = 6;
  // rx_buffer status fields
  localparam int RB_OVR   = 12;
  localparam int RB_FRM   = 13;
  localparam int RB_PAR   = 14;
  localparam int RB_SUM   = 15;
  localparam logic [2:0] MODE_7 = 3'h4;
  localparam logic [2:0] MODE_8 = 3'h5;
  localparam logic [2:0] MODE_9 = 3'h6;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_MID  = 4'h7;
  localparam logic [7:0] C0_RESET = 8'h10;
  typedef struct packed {
    logic overrun;
    logic framing;
    logic parity;
  } suart_err_type;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} suart_tx_state_type;
  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP1, RX_STOP2
  } suart_rx_state_type;
endpackage

// *** sim/suart_peer.sv ***
`timescale 1ns/1ps
module suart_peer (
  input  wire logic clk_sys,
  input  wire logic tx_line,
  output logic      rx_line
);
  // Mark level while idle, as a real line would rest
  initial begin
    rx_line = 1'b1;
  end
  task automatic send(input logic [11:0] f, input int n, input int bt);
    @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      rx_line <= f[i];
      repeat (bt) @(posedge clk_sys);
    end
    rx_line <= 1'b1;
  endtask
  // Start width measured too; needs first character bit high
  task automatic grab(output logic [9:0] d, output int w, input int n, input int bt);
    int k;
    d = '0;
    w = 0;
    k = 0;
    while (tx_line !== 1'b0 && k < 4000) begin
      @(posedge clk_sys);
      k++;
    end
    while (tx_line === 1'b0 && w < 4000) begin
      @(posedge clk_sys);
      w++;
    end
    repeat (bt / 2) @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      d[i] = tx_line;
      repeat (bt) @(posedge clk_sys);
    end
  endtask
endmodule

// *** sim/suart_core_tb_top.sv ***
`timescale 1ns/1ps
module suart_core_tb_top;
  import suart_pkg::*;
  localparam int BT = 32;
  localparam logic [7:0]  RMODE [3] = '{8'h05, 8'h65, 8'h05};
  localparam logic [11:0] RFRM  [3] = '{12'hE78, 12'hE78, 12'hC78};
  localparam int          RN    [3] = '{10, 11, 10};
  localparam logic [15:0] REXP  [3] = '{16'h003C, 16'hC03C, 16'hA03C};
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = '0;
  logic [3:0]  sel = '0;
  logic [31:0] dat = '0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        pin_o;
  logic        pin_oe;
  logic        rx_line;
  logic        tx_line;
  logic        tx_irq;
  logic        rx_irq;
  logic        rts;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          tx_n = 0;
  int          rx_n = 0;
  always #20 clk_sys = ~clk_sys;
  // Pull-up when the pin is released
  assign tx_line = pin_oe ? pin_o : 1'b1;
  always @(posedge clk_sys) begin
    if (tx_irq === 1'b1) tx_n++;
    if (rx_irq === 1'b1) rx_n++;
  end
  suart_core u_dut (
    .clk_sys           (clk_sys),
    .sys_rst           (sys_rst),
    .wb_cyc_i          (cyc),
    .wb_stb_i          (stb),
    .wb_we_i           (we),
    .wb_adr_i          (adr),
    .wb_sel_i          (sel),
    .wb_dat_i          (dat),
    .wb_dat_o          (wb_dat_o),
    .wb_ack_o          (wb_ack_o),
    .serial_in_pin     (rx_line),
    .serial_out_pin_o  (pin_o),
    .serial_out_pin_oe (pin_oe),
    .ext_clock_pin     (1'b0),
    .cts_n_pin         (1'b0),
    .rts_n_pin         (rts),
    .tx_irq_req        (tx_irq),
    .rx_irq_req        (rx_irq)
  );
  suart_peer u_peer (
    .clk_sys (clk_sys),
    .tx_line (tx_line),
    .rx_line (rx_line)
  );
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Classic cycle held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk_sys);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      error_cnt++;
      final_report();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0000_0000, q);
  endtask
  initial begin
    logic [31:0] q;
    logic [9:0]  d;
    int          w;
    int          n0;
    int          k;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(ADR_C0, q);
    chk("ctrl zero", 32'h0000_0010, q & 32'h0000_00F7);
    rd(ADR_C1, q);
    chk("ctrl one", 32'h0000_0002, q);
    rd(8'h40, q);
    chk("unmapped", 32'h0000_0000, q);
    chk("idle pin", 32'h0000_0001, {31'h0, tx_line});
    chk("rts idle", 32'h0000_0001, {31'h0, rts});
    $display("test reset done");
    wr(ADR_BRG, 32'h0000_0001);
    wr(ADR_MODE, {29'h0, MODE_8});
    wr(ADR_C1, 32'h0000_0005);
    n0 = tx_n;
    fork
      wr(ADR_TXB, 32'h0000_00A5);
      u_peer.grab(d, w, 9, BT);
    join
    chk("tx frame", 32'h0000_01A5, {22'h0, d});
    chk("bit width", BT, w);
    chk("tx irq", n0 + 1, tx_n);
    rd(ADR_C0, q);
    chk("shift empty", 32'h0000_0001, {31'h0, q[C0_SHEMP]});
    $display("test lsb transmit done");
    // Order select only with 8-bit characters
    wr(ADR_C0, 32'h0000_0090);
    wr(ADR_C1, 32'h0000_0015);
    n0 = tx_n;
    fork
      wr(ADR_TXB, 32'h0000_00B1);
      u_peer.grab(d, w, 9, BT);
    join
    chk("msb frame", 32'h0000_018D, {22'h0, d});
    chk("tx done irq", n0 + 1, tx_n);
    wr(ADR_C0, 32'h0000_0010);
    $display("test msb transmit done");
    for (int i = 0; i < 3; i++) begin
      // Disabling receive is the only way to clear the overrun flag
      wr(ADR_C1, 32'h0000_0001);
      wr(ADR_MODE, {24'h0, RMODE[i]});
      wr(ADR_C1, 32'h0000_0005);
      n0 = rx_n;
      u_peer.send(RFRM[i], RN[i], BT);
      k = 0;
      while (rx_n == n0 && k < BT) begin
        @(posedge clk_sys);
        k++;
      end
      chk("rx irq", n0 + 1, rx_n);
      rd(ADR_RXB, q);
      chk("rx word", {16'h0, REXP[i]}, q & 32'h0000_F1FF);
    end
    $display("test receive done");
    wr(ADR_C1, 32'h0000_0001);
    wr(ADR_MODE, 32'h0000_0005);
    wr(ADR_C1, 32'h0000_0005);
    n0 = rx_n;
    u_peer.send(12'hE78, 10, BT);
    u_peer.send(12'hE5A, 10, BT);
    repeat (4) @(posedge clk_sys);
    chk("overrun irq", n0 + 1, rx_n);
    rd(ADR_RXB, q);
    chk("overrun flags", 32'h0000_9000, q & 32'h0000_F000);
    $display("test overrun done");
    wr(ADR_MODE, 32'h0000_0085);
    rd(ADR_MODE, q);
    chk("inverted idle", 32'h0000_0000, {31'h0, tx_line});
    wr(ADR_MODE, 32'h0000_0005);
    wr(ADR_C0, 32'h0000_0030);
    rd(ADR_C0, q);
    chk("released pin", 32'h0000_0000, {31'h0, pin_oe});
    $display("test pin modes done");
    final_report();
  end
endmodule
